// [verilog/sebp_pkg.sv]
package sebp_pkg;
	localparam int unsigned SEBP_ADDR_W       = 2;
	localparam int unsigned SEBP_DATA_W       = 16;
	localparam int unsigned SEBP_WORD_W       = 8;
	localparam logic [1:0]  SEBP_CON1_ADDR    = 2'h0;
	localparam logic [1:0]  SEBP_CON2_ADDR    = 2'h1;
	localparam logic [1:0]  SEBP_STAT_ADDR    = 2'h2;
	localparam logic [1:0]  SEBP_BUF_ADDR     = 2'h3;
	// first control register
	localparam int unsigned SEBP_MSEL_BIT     = 5;
	localparam int unsigned SEBP_CKP_BIT      = 6;
	localparam int unsigned SEBP_SLAVE_SELECT_ENABLE_BIT     = 7;
	localparam int unsigned SEBP_CKE_BIT      = 8;
	localparam int unsigned SEBP_SMP_BIT      = 9;
	localparam logic [15:0] SEBP_CON1_MASK    = 16'h03E0;
	localparam logic [15:0] SEBP_CON1_RST     = 16'h0000;
	// second control register
	localparam int unsigned SEBP_BMODE_BIT    = 0;
	localparam logic        SEBP_BMODE_RST    = 1'b0;
	// status register
	localparam int unsigned SEBP_EN_BIT       = 15;
	localparam int unsigned SEBP_ROV_BIT      = 6;
	localparam int unsigned SEBP_TXF_BIT      = 1;
	localparam int unsigned SEBP_RXF_BIT      = 0;
	localparam logic        SEBP_EN_RST       = 1'b0;
	localparam logic        SEBP_ROV_RST      = 1'b0;
	// timing
	localparam int unsigned SEBP_CLK_NS       = 5;
	localparam int unsigned SEBP_SCK_HALF_NS  = 80;
	localparam int unsigned SEBP_SCK_HALF_CYC =
		(SEBP_SCK_HALF_NS + SEBP_CLK_NS - 1) / SEBP_CLK_NS;
	localparam int unsigned SEBP_FIFO_DEPTH   = 8;

	typedef enum logic {
		SEBP_IDLE,
		SEBP_XFER
	} sebp_state_t;
endpackage : sebp_pkg

// [verilog/sebp_mem_if.sv]
interface sebp_mem_if #(
	parameter int AW = 3,
	parameter int DW = 8
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : sebp_mem_if

// [verilog/sebp_fifo_mem.sv]
module sebp_fifo_mem
	import sebp_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int DW    = 8
) (
	input  wire logic clk_sys_i,
	sebp_mem_if.mem   port
);
	logic [DW-1:0] store_r [DEPTH];
	logic [DW-1:0] q_r;

	// write-through so a word written this cycle is readable next cycle
	always_ff @(posedge clk_sys_i) begin
		if (port.wr_en) begin
			store_r[port.wr_addr] <= port.wr_data;
		end
		if (port.wr_en && port.wr_addr == port.rd_addr) begin
			q_r <= port.wr_data;
		end else begin
			q_r <= store_r[port.rd_addr];
		end
	end

	assign port.rd_data = q_r;
endmodule : sebp_fifo_mem

// [verilog/sebp_sync.sv]
module sebp_sync
	import sebp_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : sebp_sync

// [verilog/sebp_port.sv]
// Behaviour
// - overflow flag, status bit 6, is cleared by software writing it zero
// - buffer_mode_select, second control bit 0, switches to multi-entry buffering
// - serial side runs only while port_enable, status bit 15, is set
// - master starts shifting as soon as a word is written to the buffer
// - transmit_full, status bit 1, high while transmit storage full
// - standard mode: buffer write sets transmit_full
// - standard mode: move into shift register clears transmit_full
// - enhanced mode: full when last entry written, clear when any entry frees
// - receive_full, status bit 0, high while receive storage is full
// - standard mode: word moved into receive holding sets receive_full
// - standard mode: software buffer read clears receive_full
// - enhanced mode: receive_full set when last unread entry fills
// - enhanced mode: receive_full clears once any entry is free again
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
module sebp_port
	import sebp_pkg::*;
#(
	parameter int DEPTH    = SEBP_FIFO_DEPTH,
	parameter int HALF_CYC = SEBP_SCK_HALF_CYC
) (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_i,
	input  wire logic [SEBP_ADDR_W-1:0] addr_i,
	input  wire logic [SEBP_DATA_W-1:0] wr_data_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [SEBP_DATA_W-1:0] rd_data_o,
	input  wire logic                   sck_i,
	output logic                        sck_o,
	output logic                        sck_oe_o,
	output logic                        sdo_o,
	input  wire logic                   sdi_i,
	input  wire logic                   slave_select_pin_n_i
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	typedef struct packed {
		sebp_state_t            st;
		logic [15:0]            con1;
		logic                   bmode;
		logic                   en;
		logic                   rov;
		logic [CW-1:0]          tx_cnt;
		logic [CW-1:0]          rx_cnt;
		logic [AW-1:0]          tx_wp;
		logic [AW-1:0]          tx_rp;
		logic [AW-1:0]          rx_wp;
		logic [AW-1:0]          rx_rp;
		logic [SEBP_WORD_W-1:0] txsh;
		logic [SEBP_WORD_W-1:0] rxsh;
		logic [3:0]             samp_cnt;
		logic [4:0]             edge_cnt;
		logic [7:0]             div;
		logic                   loaded;
		logic                   fresh;
		logic                   sck;
		logic                   sck_oe;
		logic                   sdo;
		logic                   sck_d;
		logic [15:0]            rd_data;
	} sebp_regs_t;

	sebp_regs_t             r;
	sebp_regs_t             n;
	logic [2:0]             pins_s;
	logic                   sck_s;
	logic                   sdi_s;
	logic                   ssn_s;
	logic                   tx_push;
	logic                   tx_pop;
	logic                   rx_push;
	logic                   rx_pop;
	logic                   ovf_set;
	logic                   lead;
	logic                   trail;
	logic                   smp_now;
	logic                   shf_now;
	logic                   tx_full;
	logic                   rx_full;
	logic [CW-1:0]          cap;
	logic [15:0]            stat_v;
	logic [SEBP_WORD_W-1:0] rx_word;
	logic                   msel;
	logic                   cke;
	logic                   ckp;
	logic                   slave_select_enable;

	sebp_mem_if #(.AW(AW), .DW(SEBP_WORD_W)) tx_mem ();
	sebp_mem_if #(.AW(AW), .DW(SEBP_WORD_W)) rx_mem ();

	sebp_sync #(.W(3)) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.d_i       ({slave_select_pin_n_i, sdi_i, sck_i}),
		.q_o       (pins_s)
	);

	sebp_fifo_mem #(.DEPTH(DEPTH), .DW(SEBP_WORD_W)) u_tx_mem (
		.clk_sys_i (clk_sys_i),
		.port      (tx_mem.mem)
	);

	sebp_fifo_mem #(.DEPTH(DEPTH), .DW(SEBP_WORD_W)) u_rx_mem (
		.clk_sys_i (clk_sys_i),
		.port      (rx_mem.mem)
	);

	assign sck_s = pins_s[0];
	assign sdi_s = pins_s[1];
	assign ssn_s = pins_s[2];
	assign msel  = r.con1[SEBP_MSEL_BIT];
	assign cke   = r.con1[SEBP_CKE_BIT];
	assign ckp   = r.con1[SEBP_CKP_BIT];
	assign slave_select_enable  = r.con1[SEBP_SLAVE_SELECT_ENABLE_BIT];

	// single entry in standard mode, DEPTH entries in enhanced mode
	assign cap     = r.bmode ? CW'(DEPTH) : CW'(1);
	assign tx_full = r.tx_cnt >= cap;
	assign rx_full = r.rx_cnt >= cap;
	assign rx_word = {r.rxsh[SEBP_WORD_W-2:0], sdi_s};

	always_comb begin
		stat_v               = '0;
		stat_v[SEBP_EN_BIT]  = r.en;
		stat_v[SEBP_ROV_BIT] = r.rov;
		stat_v[SEBP_TXF_BIT] = tx_full;
		stat_v[SEBP_RXF_BIT] = rx_full;
	end

	always_comb begin
		n         = r;
		n.rd_data = '0;
		n.sck_d   = sck_s;
		tx_push   = 1'b0;
		tx_pop    = 1'b0;
		rx_push   = 1'b0;
		rx_pop    = 1'b0;
		ovf_set   = 1'b0;
		lead      = 1'b0;
		trail     = 1'b0;
		smp_now   = 1'b0;
		shf_now   = 1'b0;
		// register writes
		if (wr_i) begin
			if (addr_i == SEBP_CON1_ADDR) begin
				n.con1 = wr_data_i & SEBP_CON1_MASK;
			end else if (addr_i == SEBP_CON2_ADDR) begin
				n.bmode = wr_data_i[SEBP_BMODE_BIT];
			end else if (addr_i == SEBP_STAT_ADDR) begin
				n.en = wr_data_i[SEBP_EN_BIT];
				if (!wr_data_i[SEBP_ROV_BIT]) begin
					n.rov = 1'b0;
				end
			end else begin
				tx_push = r.en && !tx_full;
			end
		end
		// register reads
		if (rd_i) begin
			if (addr_i == SEBP_CON1_ADDR) begin
				n.rd_data = r.con1;
			end else if (addr_i == SEBP_CON2_ADDR) begin
				n.rd_data = {15'h0000, r.bmode};
			end else if (addr_i == SEBP_STAT_ADDR) begin
				n.rd_data = stat_v;
			end else begin
				n.rd_data = {8'h00, rx_mem.rd_data};
				rx_pop    = r.rx_cnt != '0;
			end
		end
		// serial engine
		if (msel) begin
			n.sck_oe = r.en;
			case (r.st)
				SEBP_IDLE: begin
					n.sck = ckp;
					if (r.en && r.tx_cnt != '0) begin
						tx_pop     = 1'b1;
						n.txsh     = tx_mem.rd_data;
						n.fresh    = 1'b1;
						n.st       = SEBP_XFER;
						n.div      = '0;
						n.edge_cnt = '0;
						n.samp_cnt = '0;
					end
				end
				SEBP_XFER: begin
					if (r.div == 8'(HALF_CYC - 1)) begin
						n.div      = '0;
						n.sck      = !r.sck;
						lead       = r.sck == ckp;
						trail      = r.sck != ckp;
						n.edge_cnt = r.edge_cnt + 5'h01;
						if (r.edge_cnt == 5'h0F) begin
							n.st = SEBP_IDLE;
						end
					end else begin
						n.div = r.div + 8'h01;
					end
				end
				default: begin
					n.st = SEBP_IDLE;
				end
			endcase
		end else begin
			n.sck_oe = 1'b0;
			n.sck    = ckp;
			n.st     = SEBP_IDLE;
			if (slave_select_enable && ssn_s) begin
				n.samp_cnt = '0;
			end else if (r.en && sck_s != r.sck_d) begin
				lead  = r.sck_d == ckp;
				trail = r.sck_d != ckp;
			end
			if (r.en && !r.loaded && r.samp_cnt == '0 && r.tx_cnt != '0 && !lead && !trail) begin
				tx_pop   = 1'b1;
				n.txsh   = tx_mem.rd_data;
				n.loaded = 1'b1;
				n.fresh  = 1'b1;
			end
		end
		// shared sample and shift on link edges
		if (lead || trail) begin
			smp_now = cke ? lead : trail;
			shf_now = cke ? (trail && r.samp_cnt != '0) : (lead && !r.fresh);
			if (lead) begin
				n.fresh = 1'b0;
			end
			if (shf_now) begin
				n.txsh = {r.txsh[SEBP_WORD_W-2:0], 1'b0};
			end
			if (smp_now) begin
				n.rxsh     = rx_word;
				n.samp_cnt = r.samp_cnt + 4'h1;
				if (r.samp_cnt == 4'h7) begin
					n.samp_cnt = '0;
					n.loaded   = 1'b0;
					if (rx_full) begin
						ovf_set = 1'b1;
					end else begin
						rx_push = 1'b1;
					end
				end
			end
		end
		if (ovf_set) begin
			n.rov = 1'b1;
		end
		n.sdo = n.txsh[SEBP_WORD_W-1];
		// ring pointers keep words in arrival order
		if (tx_push) begin
			n.tx_wp = r.tx_wp + AW'(1);
		end
		if (tx_pop) begin
			n.tx_rp = r.tx_rp + AW'(1);
		end
		if (rx_push) begin
			n.rx_wp = r.rx_wp + AW'(1);
		end
		if (rx_pop) begin
			n.rx_rp = r.rx_rp + AW'(1);
		end
		n.tx_cnt = r.tx_cnt + CW'(tx_push) - CW'(tx_pop);
		n.rx_cnt = r.rx_cnt + CW'(rx_push) - CW'(rx_pop);
		// disabled port holds the engine and buffers empty
		if (!r.en) begin
			n.st       = SEBP_IDLE;
			n.samp_cnt = '0;
			n.edge_cnt = '0;
			n.div      = '0;
			n.loaded   = 1'b0;
			n.tx_cnt   = '0;
			n.rx_cnt   = '0;
			n.tx_wp    = '0;
			n.tx_rp    = '0;
			n.rx_wp    = '0;
			n.rx_rp    = '0;
		end
	end

	assign tx_mem.wr_en   = tx_push;
	assign tx_mem.wr_addr = r.tx_wp;
	assign tx_mem.wr_data = wr_data_i[SEBP_WORD_W-1:0];
	assign tx_mem.rd_addr = n.tx_rp;
	assign rx_mem.wr_en   = rx_push;
	assign rx_mem.wr_addr = r.rx_wp;
	assign rx_mem.wr_data = rx_word;
	assign rx_mem.rd_addr = n.rx_rp;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r       <= '0;
			r.con1  <= SEBP_CON1_RST;
			r.bmode <= SEBP_BMODE_RST;
			r.en    <= SEBP_EN_RST;
			r.rov   <= SEBP_ROV_RST;
		end else begin
			r <= n;
		end
	end

	assign rd_data_o = r.rd_data;
	assign sck_o     = r.sck;
	assign sck_oe_o  = r.sck_oe;
	assign sdo_o     = r.sdo;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	sequence xfer_begin;
		r.st == SEBP_XFER && sck_o == ckp;
	endsequence

	sequence first_clock_edge;
		##[1:300] (sck_o != ckp);
	endsequence

	rov_clear_a: assert property (
		wr_i && addr_i == SEBP_STAT_ADDR && !wr_data_i[SEBP_ROV_BIT] && !ovf_set
		|=> !stat_v[SEBP_ROV_BIT])
		else $error("overflow flag not cleared by write");

	std_single_a: assert property (
		tx_push && !r.bmode |-> r.tx_cnt == '0)
		else $error("standard mode accepted a second word");

	disabled_idle_a: assert property (
		!r.en |=> r.st == SEBP_IDLE && r.tx_cnt == '0 && !sck_oe_o)
		else $error("engine active while port disabled");

	master_start_a: assert property (
		r.en && msel && r.st == SEBP_IDLE && r.tx_cnt != '0 && wr_i == 1'b0
		|=> xfer_begin ##0 first_clock_edge)
		else $error("master did not start shifting");

	txf_set_a: assert property (
		tx_push && !r.bmode |=> stat_v[SEBP_TXF_BIT])
		else $error("transmit full not set on write");

	txf_clear_a: assert property (
		tx_pop && !tx_push && r.en && !$rose(r.en) |=> !stat_v[SEBP_TXF_BIT])
		else $error("transmit full not cleared on load");

	rxf_set_a: assert property (
		rx_push && !rx_pop && r.rx_cnt == cap - CW'(1) |=> stat_v[SEBP_RXF_BIT])
		else $error("receive full not set when last entry filled");

	rxf_clear_a: assert property (
		rx_pop && !rx_push && r.en && !wr_i |=> !stat_v[SEBP_RXF_BIT])
		else $error("receive full not cleared after read");

	ovf_keep_a: assert property (
		ovf_set && !rx_pop && !wr_i |=> r.rov && $stable(r.rx_cnt))
		else $error("overflow word was stored or flag not set");
endmodule : sebp_port

// [tb/sebp_far_end.sv]
module sebp_far_end (
	input  wire logic sck_i,
	input  wire logic act_i,
	input  wire logic sdo_i,
	output logic      sdi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh_r = 8'h50;
	logic [7:0] rx_r;
	int         nb;
	int         cnt;
	logic [7:0] got [0:31];
	assign sdi_o = sh_r[7];
	// sample on leading edge, reply word numbered
	always @(posedge sck_i) begin
		if (act_i) begin
			rx_r = {rx_r[6:0], sdo_i};
			nb++;
			if (nb == 8) begin
				got[cnt] = rx_r;
				cnt++;
				nb = 0;
				sh_r = {4'h5, 4'(cnt)};
			end
		end
	end
	// shift on trailing edge
	always @(negedge sck_i) begin
		if (act_i && nb != 0) sh_r = sh_r << 1;
	end
endmodule : sebp_far_end

// [tb/tb_sebp_port.sv]
module tb_sebp_port
	import sebp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] EN  = 16'h0001 << SEBP_EN_BIT;
	localparam logic [15:0] ROV = 16'h0001 << SEBP_ROV_BIT;
	localparam logic [15:0] TXF = 16'h0001 << SEBP_TXF_BIT;
	localparam logic [15:0] RXF = 16'h0001 << SEBP_RXF_BIT;
	localparam logic [15:0] MST = 16'h0001 << SEBP_MSEL_BIT;
	localparam logic [15:0] CKE = 16'h0001 << SEBP_CKE_BIT;
	localparam logic [15:0] SSE = 16'h0001 << SEBP_SLAVE_SELECT_ENABLE_BIT;
	localparam logic [1:0]  C1  = SEBP_CON1_ADDR;
	localparam logic [1:0]  C2  = SEBP_CON2_ADDR;
	localparam logic [1:0]  ST  = SEBP_STAT_ADDR;
	localparam logic [1:0]  BF  = SEBP_BUF_ADDR;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        wr     = 1'b0;
	logic        rd     = 1'b0;
	logic        tb_sck = 1'b0;
	logic        tb_sdi = 1'b0;
	logic        sel_n  = 1'b1;
	logic [1:0]  addr   = 2'h0;
	logic [15:0] wd     = 16'h0000;
	logic [15:0] rdat;
	logic        sck_o;
	logic        sck_oe;
	logic        sdo;
	logic        far_sdi;
	wire         sck_ln = sck_oe ? sck_o : tb_sck;
	wire         sdi_ln = sck_oe ? far_sdi : tb_sdi;
	int          err_count;
	int          n_compared;
	int          cyc;

	sebp_port u_sebp_port (
		.clk_sys_i           (clk),
		.rst_i               (rst),
		.addr_i              (addr),
		.wr_data_i           (wd),
		.wr_i                (wr),
		.rd_i                (rd),
		.rd_data_o           (rdat),
		.sck_i               (sck_ln),
		.sck_o               (sck_o),
		.sck_oe_o            (sck_oe),
		.sdo_o               (sdo),
		.sdi_i               (sdi_ln),
		.slave_select_pin_n_i(sel_n)
	);

	sebp_far_end u_sebp_far_end (
		.sck_i(sck_ln),
		.act_i(sck_oe),
		.sdo_i(sdo),
		.sdi_o(far_sdi)
	);

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd   <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask : rd_reg

	task automatic rd_chk(input logic [1:0] a, input logic [15:0] e, input string nm);
		logic [15:0] d;
		rd_reg(a, d);
		chk(nm, d, e);
	endtask : rd_chk

	// poll status until masked bits match, bounded
	task automatic wait_st(input logic [15:0] m, input logic [15:0] v);
		logic [15:0] d;
		for (int i = 0; i < 2000; i++) begin
			rd_reg(ST, d);
			if ((d & m) === v) break;
		end
	endtask : wait_st

	task automatic wait_far(input int n);
		for (int i = 0; i < 4000 && u_sebp_far_end.cnt < n; i++) @(posedge clk);
	endtask : wait_far

	task automatic t_regs();
		rd_chk(C1, SEBP_CON1_RST, "con1 reset");
		rd_chk(ST, 16'h0000, "stat reset");
		wr_reg(C1, 16'hFFFF);
		rd_chk(C1, SEBP_CON1_MASK, "con1 bits");
		wr_reg(C2, 16'hFFFF);
		rd_chk(C2, 16'h0001, "con2 bits");
		wr_reg(C2, 16'h0000);
	endtask : t_regs

	task automatic t_off();
		wr_reg(C1, MST | CKE);
		wr_reg(BF, 16'h0011);
		repeat (40) @(posedge clk);
		chk("oe off", 16'(sck_oe), 16'h0000);
		rd_chk(ST, 16'h0000, "stat off");
	endtask : t_off

	task automatic t_std();
		wr_reg(ST, 16'h0000);
		wr_reg(ST, EN);
		wr_reg(BF, 16'h00A5);
		wr_reg(BF, 16'h003C);
		rd_chk(ST, EN | TXF, "std txf");
		wait_st(RXF | TXF, RXF);
		rd_chk(ST, EN | RXF, "std rxf");
		rd_chk(BF, 16'h0050, "std rx0");
		rd_chk(ST, EN, "std read");
		wait_st(RXF, RXF);
		wr_reg(BF, 16'h005A);
		wait_far(3);
		wait_st(ROV, ROV);
		rd_chk(ST, EN | RXF | ROV, "ovf set");
		wr_reg(ST, EN);
		rd_chk(ST, EN | RXF, "ovf clear");
		rd_chk(BF, 16'h0051, "std rx1");
		chk("far 0", 16'(u_sebp_far_end.got[0]), 16'h00A5);
		chk("far 1", 16'(u_sebp_far_end.got[1]), 16'h003C);
		chk("far 2", 16'(u_sebp_far_end.got[2]), 16'h005A);
	endtask : t_std

	task automatic t_enh();
		wr_reg(ST, 16'h0000);
		wr_reg(C2, 16'h0001);
		wr_reg(ST, EN);
		for (int i = 0; i < 9; i++) wr_reg(BF, 16'h0080 + 16'(i));
		rd_chk(ST, EN | TXF, "enh txf");
		wait_st(TXF, 16'h0000);
		rd_chk(ST, EN, "enh tx free");
		wait_st(RXF, RXF);
		rd_chk(ST, EN | RXF, "enh rxf");
		rd_chk(BF, 16'h0053, "enh rx3");
		rd_chk(ST, EN, "enh rx free");
		wait_far(12);
		wait_st(RXF, RXF);
		rd_chk(ST, EN | RXF, "enh refill");
		for (int i = 4; i < 12; i++) rd_chk(BF, 16'h0050 + 16'(i), "enh rx");
		rd_chk(ST, EN, "enh empty");
		for (int i = 0; i < 9; i++) begin
			chk("enh far", 16'(u_sebp_far_end.got[3 + i]), 16'h0080 + 16'(i));
		end
	endtask : t_enh

	task automatic t_slave();
		logic [7:0] tx;
		logic [7:0] rx;
		tx = 8'hC3;
		rx = 8'h96;
		wr_reg(ST, 16'h0000);
		wr_reg(C2, 16'h0000);
		wr_reg(C1, SSE | CKE);
		wr_reg(ST, EN);
		repeat (4) @(posedge clk);
		chk("slave oe", 16'(sck_oe), 16'h0000);
		wr_reg(BF, {8'h00, tx});
		sel_n <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			tb_sdi <= rx[b];
			repeat (16) @(posedge clk);
			chk("slave sdo", 16'(sdo), 16'(tx[b]));
			tb_sck <= 1'b1;
			repeat (16) @(posedge clk);
			tb_sck <= 1'b0;
		end
		repeat (16) @(posedge clk);
		sel_n <= 1'b1;
		wait_st(RXF, RXF);
		rd_chk(BF, {8'h00, rx}, "slave rx");
	endtask : t_slave

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_off();
		t_std();
		t_enh();
		t_slave();
		print_verdict();
	end
endmodule : tb_sebp_port
